/* rtl/msrm_params.svh */
// Purpose: Offsets, field positions, reset values and command codes
// Assumes: Seven-bit register addresses on the serial port
// Notes:   Definitions only
`ifndef MSRM_PARAMS_SVH
`define MSRM_PARAMS_SVH

`define MSRM_A_PART       7'h00
`define MSRM_A_REV        7'h01
`define MSRM_A_MOTION     7'h02
`define MSRM_A_XL         7'h03
`define MSRM_A_YL         7'h04
`define MSRM_A_XYH        7'h05
`define MSRM_A_SURFACE_QUALITY      7'h06
`define MSRM_A_EXPH       7'h07
`define MSRM_A_EXPL       7'h08
`define MSRM_A_PEAK       7'h09
`define MSRM_A_TOTAL      7'h0a
`define MSRM_A_LOWEST     7'h0b
`define MSRM_A_CK0        7'h0c
`define MSRM_A_CK3        7'h0f
`define MSRM_A_SELF       7'h10
`define MSRM_A_CFG2       7'h12
`define MSRM_A_LCA        7'h1a
`define MSRM_A_LPA        7'h1c
`define MSRM_A_LPB        7'h1d
`define MSRM_A_LCB        7'h1f
`define MSRM_A_OBS        7'h2e
`define MSRM_A_PIX        7'h35
`define MSRM_A_HRES       7'h36
`define MSRM_A_PWRUP      7'h3a
`define MSRM_A_PDOWN      7'h3b
`define MSRM_A_PDTHR      7'h3d
`define MSRM_A_REVC       7'h3e
`define MSRM_A_PARTC      7'h3f
`define MSRM_A_BURST      7'h42

`define MSRM_B_MOV        7
`define MSRM_B_PIXEL_BYTE_READY     6
`define MSRM_B_ORIGIN     5
`define MSRM_B_OVF        4
`define MSRM_B_LPV        3
`define MSRM_B_FAULT      2

`define MSRM_R_CFG2       8'h28
`define MSRM_R_HRES       8'h04
`define MSRM_R_PDTHR      8'h56
`define MSRM_R_EXPL       8'h64
`define MSRM_R_PEAK       8'hd0
`define MSRM_R_TOTAL      8'h80

`define MSRM_C_PWRUP      8'h5a
`define MSRM_C_PDOWN      8'he7

`endif

/* rtl/msrm_pkg.sv */
// Purpose: Types shared by the motion sensor register map
// Assumes: Nothing beyond the params header
// Notes:   Link states follow a Gray path
package msrm_pkg;

  typedef enum logic [1:0]
  {
    MSRM_ADDR  = 2'b00,
    MSRM_RDATA = 2'b01,
    MSRM_DONE  = 2'b11,
    MSRM_WDATA = 2'b10
  } msrm_link_state_type;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] dx;
    logic [7:0] dy;
  } msrm_motion_type;

  typedef struct packed
  {
    logic       valid;
    logic       first_px;
    logic [7:0] data;
  } msrm_pixel_type;

  typedef struct packed
  {
    logic        valid;
    logic [7:0]  surface_quality;
    logic [15:0] exposure;
    logic [7:0]  peak;
    logic [7:0]  total;
    logic [7:0]  lowest;
    logic [31:0] checksum;
  } msrm_stats_type;

  typedef struct packed
  {
    logic [7:0] config_two;
    logic [7:0] laser_control_a;
    logic [7:0] laser_control_b;
    logic [7:0] laser_power_cfg_a;
    logic [7:0] laser_power_cfg_b;
    logic [7:0] horizontal_resolution;
    logic [7:0] power_down_threshold;
  } msrm_config_type;

endpackage

/* rtl/msrm_top.sv */
// Purpose: Register map, serial slave and motion status of the sensor
// Assumes: Serial clock idles high; MOSI taken on rising, MISO on falling
// Notes:   Link logic runs on i_sclk; all of it but the held words is held in reset while NCS is high
`include "msrm_params.svh"

module msrm_top
#(
  parameter logic [7:0] PART_CODE = 8'h5e, // Arbitrary value
  parameter logic [7:0] REV_CODE  = 8'h07, // Arbitrary value
  parameter int         ACC_W     = 12
)
(
  input  wire logic                     i_mclk,          // Core clock
  input  wire logic                     i_rstn,          // Async reset
  input  wire logic                     i_ce,            // Core enable
  input  wire logic                     i_sclk,          // Serial clock
  input  wire logic                     i_ncs,           // Chip select
  input  wire logic                     i_mosi,          // Serial in
  input  wire logic                     i_laser_fault,   // Short detect
  input  wire logic [3:0]               i_obs_set,       // Observation
  input  wire msrm_pkg::msrm_motion_type i_motion,       // Frame deltas
  input  wire msrm_pkg::msrm_pixel_type  i_pixel,        // Pixel bytes
  input  wire msrm_pkg::msrm_stats_type  i_stats,        // Frame stats
  output logic                          o_miso,          // Serial out
  output logic                          o_miso_oe,       // Out enable
  output msrm_pkg::msrm_config_type     o_config,        // Settings
  output logic                          o_pixel_restart, // Pulse
  output logic                          o_pixel_next,    // Pulse
  output logic                          o_self_check,    // Pulse
  output logic                          o_powerup,       // Pulse
  output logic                          o_powered_down   // Level
);

  if (ACC_W != 12)
  begin : g_chk
    $error("msrm_top: high register packing needs ACC_W of 12");
  end

  logic                          link_rst_n;
  msrm_pkg::msrm_link_state_type state_q;
  logic [2:0]                    cnt_q;
  logic [7:0]                    sh_q;
  logic [6:0]                    osh_q;
  logic [6:0]                    haddr_q;
  logic [7:0]                    hdata_q;
  logic                          rd_tgl_q;
  logic                          wr_tgl_q;
  logic [2:0]                    s1_q;
  logic [2:0]                    s2_q;
  logic [2:1]                    s3_q;
  logic                          rd_evt;
  logic                          wr_evt;
  logic                          wr_ok;
  logic [7:0]                    rd_data_q;
  logic [7:0]                    rd_mux;
  logic [7:0]                    status;
  logic [ACC_W-1:0]              acc_x_q;
  logic [ACC_W-1:0]              acc_y_q;
  logic [ACC_W-1:0]              snap_x_q;
  logic [ACC_W-1:0]              snap_y_q;
  logic [ACC_W:0]                sum_x;
  logic [ACC_W:0]                sum_y;
  logic                          ovf_hit;
  logic                          mov_q;
  logic                          ovf_q;
  logic                          pixel_byte_ready_q;
  logic                          origin_q;
  logic [7:0]                    pix_q;
  logic                          lpv_q;
  logic [7:0]                    obs_q;
  msrm_pkg::msrm_stats_type      stats_q;

  // NCS high ends every frame, whatever the serial clock does
  assign link_rst_n = i_rstn & ~i_ncs;

  always_ff @(posedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_q <= msrm_pkg::MSRM_ADDR;
      cnt_q   <= 3'h0;
      sh_q    <= 8'h00;
    end
    else
    begin
      sh_q  <= {sh_q[6:0], i_mosi};
      cnt_q <= cnt_q + 3'h1;
      case (state_q)
        msrm_pkg::MSRM_ADDR:
        begin
          if (cnt_q == 3'h7)
          begin
            if (sh_q[6])
            begin
              state_q <= msrm_pkg::MSRM_WDATA;
            end
            else
            begin
              state_q <= msrm_pkg::MSRM_RDATA;
            end
          end
        end
        msrm_pkg::MSRM_WDATA,
        msrm_pkg::MSRM_RDATA:
        begin
          if (cnt_q == 3'h7)
          begin
            state_q <= msrm_pkg::MSRM_DONE;
          end
        end
        msrm_pkg::MSRM_DONE:
        begin
          state_q <= msrm_pkg::MSRM_DONE;
        end
        default:
        begin
          state_q <= msrm_pkg::MSRM_ADDR;
        end
      endcase
    end
  end

  // Held words survive NCS so the core can pick them up after the frame
  always_ff @(posedge i_sclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      haddr_q  <= 7'h00;
      hdata_q  <= 8'h00;
      rd_tgl_q <= 1'b0;
      wr_tgl_q <= 1'b0;
    end
    else if (i_ncs == 1'b0)
    begin
      if (state_q == msrm_pkg::MSRM_ADDR && cnt_q == 3'h7)
      begin
        haddr_q <= {sh_q[5:0], i_mosi};
        if (!sh_q[6])
        begin
          rd_tgl_q <= ~rd_tgl_q;
        end
      end
      if (state_q == msrm_pkg::MSRM_WDATA && cnt_q == 3'h7)
      begin
        hdata_q  <= {sh_q[6:0], i_mosi};
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // Read byte is quasi-static: the host waits after the address, so the
  // core has long settled it before the first data falling edge
  always_ff @(negedge i_sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
      osh_q     <= 7'h00;
    end
    else
    begin
      o_miso_oe <= 1'b1;
      if (state_q == msrm_pkg::MSRM_RDATA && cnt_q == 3'h0)
      begin
        o_miso <= rd_data_q[7];
        osh_q  <= rd_data_q[6:0];
      end
      else
      begin
        o_miso <= osh_q[6];
        osh_q  <= {osh_q[5:0], 1'b0};
      end
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
      if (!i_rstn)
      begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end
      else if (i_ce)
      begin
        s1_q[i] <= (i == 0) ? i_laser_fault :
                   (i == 1) ? rd_tgl_q : wr_tgl_q;
        s2_q[i] <= s1_q[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s3_q <= 2'h0;
    end
    else if (i_ce)
    begin
      s3_q <= s2_q[2:1];
    end
  end

  assign rd_evt = i_ce & (s2_q[1] ^ s3_q[1]);
  assign wr_evt = i_ce & (s2_q[2] ^ s3_q[2]);
  // While powered down only the power-up command is honoured
  assign wr_ok  = wr_evt & (~o_powered_down | (haddr_q == `MSRM_A_PWRUP));

  always_comb
  begin
    status                = 8'h00;
    status[`MSRM_B_MOV]    = mov_q;
    status[`MSRM_B_PIXEL_BYTE_READY] = pixel_byte_ready_q;
    status[`MSRM_B_ORIGIN] = origin_q;
    status[`MSRM_B_OVF]    = ovf_q;
    status[`MSRM_B_LPV]    = lpv_q;
    status[`MSRM_B_FAULT]  = s2_q[0];
  end

  always_comb
  begin
    rd_mux = 8'h00;
    case (haddr_q)
      `MSRM_A_PART:   rd_mux = PART_CODE;
      `MSRM_A_REV:    rd_mux = REV_CODE;
      `MSRM_A_MOTION: rd_mux = status;
      `MSRM_A_XL:     rd_mux = snap_x_q[7:0];
      `MSRM_A_YL:     rd_mux = snap_y_q[7:0];
      `MSRM_A_XYH:    rd_mux = {snap_x_q[11:8], snap_y_q[11:8]};
      `MSRM_A_SURFACE_QUALITY:  rd_mux = stats_q.surface_quality;
      `MSRM_A_EXPH:   rd_mux = stats_q.exposure[15:8];
      `MSRM_A_EXPL:   rd_mux = stats_q.exposure[7:0];
      `MSRM_A_PEAK:   rd_mux = stats_q.peak;
      `MSRM_A_TOTAL:  rd_mux = stats_q.total;
      `MSRM_A_LOWEST: rd_mux = stats_q.lowest;
      `MSRM_A_CFG2:   rd_mux = o_config.config_two;
      `MSRM_A_LCA:    rd_mux = o_config.laser_control_a;
      `MSRM_A_LCB:    rd_mux = o_config.laser_control_b;
      `MSRM_A_LPA:    rd_mux = o_config.laser_power_cfg_a;
      `MSRM_A_LPB:    rd_mux = o_config.laser_power_cfg_b;
      `MSRM_A_OBS:    rd_mux = obs_q;
      `MSRM_A_PIX:    rd_mux = pix_q;
      `MSRM_A_HRES:   rd_mux = o_config.horizontal_resolution;
      `MSRM_A_PDTHR:  rd_mux = o_config.power_down_threshold;
      `MSRM_A_REVC:   rd_mux = ~REV_CODE;
      `MSRM_A_PARTC:  rd_mux = ~PART_CODE;
      default:
      begin
        // Checksum bytes, low byte first; burst and gaps read zero
        if (haddr_q >= `MSRM_A_CK0 && haddr_q <= `MSRM_A_CK3)
        begin
          rd_mux = stats_q.checksum[{haddr_q[1:0], 3'h0} +: 8];
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_data_q <= 8'h00;
    end
    else if (rd_evt)
    begin
      rd_data_q <= rd_mux;
    end
  end

  assign sum_x   = {acc_x_q[ACC_W-1], acc_x_q} +
                   {{(ACC_W-7){i_motion.dx[7]}}, i_motion.dx};
  assign sum_y   = {acc_y_q[ACC_W-1], acc_y_q} +
                   {{(ACC_W-7){i_motion.dy[7]}}, i_motion.dy};
  assign ovf_hit = (sum_x[ACC_W] != sum_x[ACC_W-1]) |
                   (sum_y[ACC_W] != sum_y[ACC_W-1]);

  // Status read moves the counts into the readout copy; new motion that
  // arrives in the same cycle starts the next count unless ovf_q is set or the sum overflows
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_x_q  <= '0;
      acc_y_q  <= '0;
      snap_x_q <= '0;
      snap_y_q <= '0;
      mov_q    <= 1'b0;
      ovf_q    <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_ok && haddr_q == `MSRM_A_MOTION)
      begin
        acc_x_q  <= '0;
        acc_y_q  <= '0;
        snap_x_q <= '0;
        snap_y_q <= '0;
        mov_q    <= 1'b0;
        ovf_q    <= 1'b0;
      end
      else if (rd_evt)
      begin
        case (haddr_q)
          `MSRM_A_MOTION:
          begin
            snap_x_q <= acc_x_q;
            snap_y_q <= acc_y_q;
            acc_x_q  <= '0;
            acc_y_q  <= '0;
            mov_q    <= 1'b0;
          end
          `MSRM_A_XL:  snap_x_q[7:0] <= 8'h00;
          `MSRM_A_YL:  snap_y_q[7:0] <= 8'h00;
          `MSRM_A_XYH:
          begin
            snap_x_q[11:8] <= 4'h0;
            snap_y_q[11:8] <= 4'h0;
            ovf_q          <= 1'b0;
          end
          default:
          begin
            mov_q <= mov_q;
          end
        endcase
      end
      if (i_motion.valid && !ovf_q && (i_motion.dx != 8'h00 ||
          i_motion.dy != 8'h00))
      begin
        mov_q <= 1'b1;
        if (ovf_hit)
        begin
          ovf_q <= 1'b1;
        end
        else if (rd_evt && haddr_q == `MSRM_A_MOTION)
        begin
          acc_x_q <= sum_x[ACC_W-1:0] - acc_x_q;
          acc_y_q <= sum_y[ACC_W-1:0] - acc_y_q;
        end
        else if (!(wr_ok && haddr_q == `MSRM_A_MOTION))
        begin
          acc_x_q <= sum_x[ACC_W-1:0];
          acc_y_q <= sum_y[ACC_W-1:0];
        end
        else
        begin
          acc_x_q <= sum_x[ACC_W-1:0] - acc_x_q;
          acc_y_q <= sum_y[ACC_W-1:0] - acc_y_q;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pixel_byte_ready_q        <= 1'b0;
      origin_q        <= 1'b0;
      pix_q           <= 8'h00;
      o_pixel_restart <= 1'b0;
      o_pixel_next    <= 1'b0;
    end
    else if (i_ce)
    begin
      o_pixel_restart <= 1'b0;
      o_pixel_next    <= 1'b0;
      if (wr_ok && haddr_q == `MSRM_A_PIX)
      begin
        // Restart drops any byte already taken from the old scan
        o_pixel_restart <= 1'b1;
        pixel_byte_ready_q        <= 1'b0;
        origin_q        <= 1'b1;
      end
      else if (i_pixel.valid)
      begin
        pix_q    <= i_pixel.data;
        pixel_byte_ready_q <= 1'b1;
        origin_q <= i_pixel.first_px;
      end
      else if (rd_evt && haddr_q == `MSRM_A_PIX)
      begin
        pixel_byte_ready_q     <= 1'b0;
        o_pixel_next <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_config       <= '{`MSRM_R_CFG2, 8'h00, 8'h00, 8'h00, 8'h00,
                          `MSRM_R_HRES, `MSRM_R_PDTHR};
      obs_q          <= 8'h00;
      o_self_check   <= 1'b0;
      o_powerup      <= 1'b0;
      o_powered_down <= 1'b0;
    end
    else if (i_ce)
    begin
      o_self_check <= 1'b0;
      o_powerup    <= 1'b0;
      if (wr_ok)
      begin
        case (haddr_q)
          `MSRM_A_CFG2:  o_config.config_two            <= hdata_q;
          `MSRM_A_LCA:   o_config.laser_control_a       <= hdata_q;
          `MSRM_A_LCB:   o_config.laser_control_b       <= hdata_q;
          `MSRM_A_LPA:   o_config.laser_power_cfg_a     <= hdata_q;
          `MSRM_A_LPB:   o_config.laser_power_cfg_b     <= hdata_q;
          `MSRM_A_HRES:  o_config.horizontal_resolution <= hdata_q;
          `MSRM_A_PDTHR: o_config.power_down_threshold  <= hdata_q;
          `MSRM_A_OBS:   obs_q                          <= hdata_q;
          `MSRM_A_SELF:  o_self_check                   <= 1'b1;
          `MSRM_A_PDOWN:
          begin
            if (hdata_q == `MSRM_C_PDOWN)
            begin
              o_powered_down <= 1'b1;
            end
          end
          `MSRM_A_PWRUP:
          begin
            if (hdata_q == `MSRM_C_PWRUP)
            begin
              o_powerup      <= 1'b1;
              o_powered_down <= 1'b0;
              o_config       <= '{`MSRM_R_CFG2, 8'h00, 8'h00, 8'h00,
                                  8'h00, `MSRM_R_HRES, `MSRM_R_PDTHR};
            end
          end
          default:
          begin
            obs_q <= obs_q;
          end
        endcase
      end
      // Frame logic sets observation bits; setting beats a host clear
      obs_q[3:0] <= ((wr_ok && haddr_q == `MSRM_A_OBS) ? hdata_q[3:0] :
                     obs_q[3:0]) | i_obs_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      stats_q <= '{1'b0, 8'h00, {8'h00, `MSRM_R_EXPL}, `MSRM_R_PEAK,
                   `MSRM_R_TOTAL, 8'h00, 32'h0000_0000};
      lpv_q   <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_stats.valid)
      begin
        stats_q <= i_stats;
      end
      lpv_q <= (o_config.laser_control_a == ~o_config.laser_control_b) &&
               (o_config.laser_power_cfg_a ==
                ~o_config.laser_power_cfg_b);
    end
  end

endmodule

/* tb/msrm_checker.sv */
// Purpose: Port-level assertions for the register map
// Assumes: One core clock domain; link seen only through its outputs
// Notes:   Bound to msrm_top below
module msrm_checker
(
  input wire logic                      i_mclk,          // Core clock
  input wire logic                      i_rstn,          // Async reset
  input wire logic                      i_ce,            // Core enable
  input wire logic                      i_ncs,           // Chip select
  input wire logic                      o_miso,          // Serial out
  input wire logic                      o_miso_oe,       // Out enable
  input wire msrm_pkg::msrm_config_type o_config,        // Settings
  input wire logic                      o_pixel_restart, // Pulse
  input wire logic                      o_pixel_next,    // Pulse
  input wire logic                      o_self_check,    // Pulse
  input wire logic                      o_powerup,       // Pulse
  input wire logic                      o_powered_down   // Level
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [55:0] DEF = 56'h28_0000_0000_0456;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  a_link_idle_quiet: assert property (
    i_ncs |-> !o_miso_oe && !o_miso)
    else $error("miso driven while deselected");
  a_oe_holds_frame: assert property (
    o_miso_oe && !i_ncs |=> o_miso_oe || i_ncs)
    else $error("miso enable dropped inside a frame");
  a_restart_single: assert property (
    o_pixel_restart |=> !o_pixel_restart)
    else $error("pixel restart longer than one cycle");
  a_next_spaced: assert property (
    o_pixel_next |=> !o_pixel_next [*2])
    else $error("pixel consume pulses too close");
  a_reset_defaults: assert property (
    $rose(i_rstn) |-> o_config == DEF && !o_powered_down)
    else $error("settings not at defaults after reset");
  a_powerup_defaults: assert property (
    o_powerup |-> ##[0:2] (o_config == DEF) && !o_powered_down)
    else $error("power-up did not restore settings");
  a_freeze_on_ce: assert property (
    !$past(i_ce) |-> $stable(o_config) && $stable(o_powered_down))
    else $error("state moved while core disabled");
  a_down_blocks_cfg: assert property (
    o_powered_down && $past(o_powered_down) && !o_powerup
      && !$past(o_powerup) |-> $stable(o_config))
    else $error("settings changed while powered down");
  a_down_cleared: assert property (
    $fell(o_powered_down) |->
      o_powerup || $past(o_powerup) || $past(o_powerup, 2))
    else $error("power-down left without power-up");
  a_self_pulse: assert property (
    o_self_check |=> !o_self_check)
    else $error("self check pulse too long");

  c_powerup: cover property (o_powerup);
  c_down: cover property ($rose(o_powered_down));
  c_restart: cover property (o_pixel_restart);
  c_next: cover property (o_pixel_next);
endmodule

bind msrm_top msrm_checker u_msrm_checker
(
  .i_mclk, .i_rstn, .i_ce, .i_ncs, .o_miso, .o_miso_oe, .o_config,
  .o_pixel_restart, .o_pixel_next, .o_self_check, .o_powerup,
  .o_powered_down
);

/* tb/msrm_host_model.sv */
// Purpose: Serial host driving the four-wire port
// Assumes: Clock idles high, 12 ns period, runs only inside frames
// Notes:   Undriven MISO is read inverted so it never passes by luck
module msrm_host_model
(
  input  wire logic i_miso,    // Serial data from device
  input  wire logic i_miso_oe, // Device drives MISO
  output logic      o_sclk,    // Serial clock
  output logic      o_ncs,     // Chip select
  output logic      o_mosi,    // Serial data to device
  output logic      o_oe_err   // Sticky: MISO undriven in data phase
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_sclk = 1'b1;
    o_ncs = 1'b1;
    o_mosi = 1'b1;
    o_oe_err = 1'b0;
  end

  task automatic shift_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      o_mosi = b[i];
      #6;
      o_sclk = 1'b1;
      #6;
    end
  endtask

  task automatic xfer(input logic wr, input logic [6:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    rd = 8'h00;
    #1.7;
    o_ncs = 1'b0;
    #20;
    shift_out({wr, a});
    if (wr)
    begin
      shift_out(wd);
      #100;
    end
    else
    begin
      // Wait covers the core's prepare time
      #120;
      for (int i = 7; i >= 0; i--)
      begin
        o_sclk = 1'b0;
        #6;
        o_sclk = 1'b1;
        rd[i] = i_miso_oe ? i_miso : ~i_miso;
        if (i_miso_oe !== 1'b1)
          o_oe_err = 1'b1;
        #6;
      end
    end
    o_ncs = 1'b1;
    // Released line has no pull: show the opposite level
    o_mosi = ~o_mosi;
    #100;
  endtask
endmodule

/* tb/msrm_tb_top.sv */
// Purpose: Self-checking bench for the sensor register map
// Assumes: Host model owns the serial port
// Notes:   Core-side inputs change on falling mclk
module msrm_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] PART = 8'h5e; // Arbitrary value
  localparam logic [7:0] REV  = 8'h07; // Arbitrary value
  localparam logic [6:0] RA [14] = '{7'h00, 7'h01, 7'h02, 7'h3e, 7'h3f,
    7'h08, 7'h09, 7'h0a, 7'h12, 7'h36, 7'h3d, 7'h11, 7'h42, 7'h1c};
  localparam logic [7:0] RV [14] = '{PART, REV, 8'h00, ~REV, ~PART,
    8'h64, 8'hd0, 8'h80, 8'h28, 8'h04, 8'h56, 8'h00, 8'h00, 8'h00};

  logic                      i_mclk;
  logic                      i_rstn;
  logic                      i_ce;
  logic                      i_sclk;
  logic                      i_ncs;
  logic                      i_mosi;
  logic                      i_laser_fault;
  logic [3:0]                i_obs_set;
  msrm_pkg::msrm_motion_type i_motion;
  msrm_pkg::msrm_pixel_type  i_pixel;
  msrm_pkg::msrm_stats_type  i_stats;
  logic                      o_miso;
  logic                      o_miso_oe;
  msrm_pkg::msrm_config_type o_config;
  logic                      o_pixel_restart;
  logic                      o_pixel_next;
  logic                      o_self_check;
  logic                      o_powerup;
  logic                      o_powered_down;
  logic                      oe_err;
  logic [7:0]                v;
  int                        error_cnt = 0;
  int                        n_compared = 0;
  int                        n_restart = 0;
  int                        n_self = 0;
  int                        n_pwrup = 0;
  int                        n_next = 0;

  msrm_top
  #(
    .PART_CODE (PART),
    .REV_CODE  (REV)
  )
  u_msrm_top
  (
    .i_mclk, .i_rstn, .i_ce, .i_sclk, .i_ncs, .i_mosi, .i_laser_fault,
    .i_obs_set, .i_motion, .i_pixel, .i_stats, .o_miso, .o_miso_oe,
    .o_config, .o_pixel_restart, .o_pixel_next, .o_self_check,
    .o_powerup, .o_powered_down
  );

  msrm_host_model u_msrm_host_model
  (
    .i_miso    (o_miso),
    .i_miso_oe (o_miso_oe),
    .o_sclk    (i_sclk),
    .o_ncs     (i_ncs),
    .o_mosi    (i_mosi),
    .o_oe_err  (oe_err)
  );

  always @(posedge i_mclk)
  begin
    n_restart += int'(o_pixel_restart);
    n_self += int'(o_self_check);
    n_pwrup += int'(o_powerup);
    n_next += int'(o_pixel_next);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_msrm_host_model.xfer(1'b0, a, 8'h00, d);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_msrm_host_model.xfer(1'b1, a, d, unused);
  endtask

  task automatic movement_flag(input logic [7:0] dx, input logic [7:0] dy);
    @(negedge i_mclk);
    i_motion = {1'b1, dx, dy};
    @(negedge i_mclk);
    i_motion.valid = 1'b0;
  endtask

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial
  begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    i_laser_fault = 1'b0;
    i_obs_set = 4'h0;
    i_motion = '0;
    i_pixel = '0;
    i_stats = '0;
    repeat (2) @(negedge i_mclk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_mclk);
    for (int i = 0; i < 14; i++)
    begin
      rd(RA[i], v);
      chk(v, RV[i]);
    end
    wr(7'h12, 8'ha5);
    rd(7'h12, v);
    chk(v, 8'ha5);
    chk(o_config.config_two, 8'ha5);
    wr(7'h00, 8'hff);
    rd(7'h00, v);
    chk(v, PART);
    // Laser pairs: one good pair is not enough
    wr(7'h1a, 8'h3c);
    wr(7'h1f, 8'hc3);
    rd(7'h02, v);
    chk(v & 8'h08, 8'h00);
    wr(7'h1c, 8'h0f);
    wr(7'h1d, 8'hf0);
    rd(7'h02, v);
    chk(v & 8'h08, 8'h08);
    wr(7'h1d, 8'hf1);
    rd(7'h02, v);
    chk(v & 8'h08, 8'h00);
    @(negedge i_mclk);
    i_laser_fault = 1'b1;
    rd(7'h02, v);
    chk(v & 8'h04, 8'h04);
    @(negedge i_mclk);
    i_laser_fault = 1'b0;
    rd(7'h02, v);
    chk(v & 8'h04, 8'h00);
    movement_flag(8'h05, 8'hfd);
    rd(7'h02, v);
    chk(v & 8'h80, 8'h80);
    rd(7'h03, v);
    chk(v, 8'h05);
    rd(7'h04, v);
    chk(v, 8'hfd);
    rd(7'h05, v);
    chk(v, 8'h0f);
    rd(7'h02, v);
    chk(v & 8'h80, 8'h00);
    rd(7'h03, v);
    chk(v, 8'h00);
    movement_flag(8'h01, 8'h02);
    wr(7'h02, 8'hff);
    rd(7'h02, v);
    chk(v & 8'h93, 8'h00);
    rd(7'h04, v);
    chk(v, 8'h00);
    repeat (17) movement_flag(8'h7f, 8'h00);
    rd(7'h02, v);
    chk(v & 8'h90, 8'h90);
    movement_flag(8'h03, 8'h00);
    rd(7'h03, v);
    chk(v, 8'hf0);
    rd(7'h04, v);
    chk(v, 8'h00);
    rd(7'h05, v);
    chk(v, 8'h70);
    rd(7'h02, v);
    chk(v & 8'h10, 8'h00);
    rd(7'h03, v);
    chk(v, 8'h00);
    @(negedge i_mclk);
    i_pixel = {1'b1, 1'b0, 8'h9a};
    @(negedge i_mclk);
    i_pixel.valid = 1'b0;
    rd(7'h02, v);
    chk(v & 8'h60, 8'h40);
    rd(7'h35, v);
    chk(v, 8'h9a);
    chk(8'(n_next), 8'h01);
    rd(7'h02, v);
    chk(v & 8'h40, 8'h00);
    wr(7'h35, 8'h00);
    rd(7'h02, v);
    chk(v & 8'h20, 8'h20);
    chk(8'(n_restart), 8'h01);
    wr(7'h2e, 8'h00);
    @(negedge i_mclk);
    i_obs_set = 4'ha;
    i_stats = {1'b1, 8'h33, 16'h1234, 24'h445566, 32'h88779900};
    @(negedge i_mclk);
    i_obs_set = 4'h0;
    i_stats.valid = 1'b0;
    rd(7'h2e, v);
    chk(v, 8'h0a);
    rd(7'h06, v);
    chk(v, 8'h33);
    rd(7'h07, v);
    chk(v, 8'h12);
    rd(7'h0f, v);
    chk(v, 8'h88);
    wr(7'h10, 8'h00);
    chk(8'(n_self), 8'h01);
    wr(7'h3b, 8'he7);
    chk({7'h00, o_powered_down}, 8'h01);
    wr(7'h12, 8'h11);
    chk(o_config.config_two, 8'ha5);
    wr(7'h3a, 8'h5a);
    chk({7'h00, o_powered_down}, 8'h00);
    chk(o_config.config_two, 8'h28);
    chk(8'(n_pwrup), 8'h01);
    @(negedge i_mclk);
    i_ce = 1'b0;
    // Frame completes on the link, but the core must not take it yet
    wr(7'h12, 8'h3c);
    chk(o_config.config_two, 8'h28);
    @(negedge i_mclk);
    i_ce = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk(o_config.config_two, 8'h3c);
    chk({7'h00, oe_err}, 8'h00);
    conclude();
  end
endmodule
